/* design/ufbp_pkg.sv */
// shared constants of the usb fifo byte port
package ufbp_pkg;
  localparam int unsigned BYTE_W = 8;  // width of the shared byte lines
  localparam int unsigned CNT_W  = 4;  // width of the phase counters
  // phase lengths in clk_in cycles, each loaded as length minus one
  localparam logic [3:0] SETUP_CYC = 4'h2; // data driven before strobe
  localparam logic [3:0] WRHI_CYC  = 4'h2; // write strobe high time
  localparam logic [3:0] HOLD_CYC  = 4'h3; // data held after strobe fall
  localparam logic [3:0] RDLO_CYC  = 4'h7; // read strobe low time
  localparam logic [3:0] GUARD_CYC = 4'h8; // settle time after a transfer
  localparam logic [3:0] ONE       = 4'h1; // counter step
  // reset and idle values of the link
  localparam logic [7:0] IDLE_BYTE = 8'hff; // pulled-up level of idle lines
  localparam logic [1:0] CNT_EMPTY = 2'h0;  // buffer fill levels
  localparam logic [1:0] CNT_ONE   = 2'h1;
  localparam logic [1:0] CNT_FULL  = 2'h2;
  // host sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_SETUP = 7'h02,
    ST_WRHI  = 7'h04,
    ST_HOLD  = 7'h08,
    ST_RDLO  = 7'h10,
    ST_GUARD = 7'h20,
    ST_AUX   = 7'h40
  } ufbp_state_e;
endpackage : ufbp_pkg

/* design/ufbp_link_if.sv */
// interface joining the usb chip end and the logic end of the byte port
interface ufbp_link_if;
  logic       tx_space_n;  // low: chip can take a byte toward the pc
  logic       rx_avail_n;  // low: chip holds an unread byte from the pc
  logic       wr;          // write strobe, byte taken on its fall
  logic       rd_n;        // read strobe, chip drives lines while low
  logic [7:0] host_data;   // byte driven by the logic end
  logic       host_oe_n;   // low while the logic end drives
  logic [7:0] dev_data;    // byte driven by the chip end
  logic       dev_oe_n;    // low while the chip end drives
  logic [7:0] byte_lines;  // resolved level of the shared lines

  // resolve the shared lines; idle lines read as pulled up
  assign byte_lines = !host_oe_n ? host_data :
                      !dev_oe_n  ? dev_data  : ufbp_pkg::IDLE_BYTE;

  modport dev
  (
    input  wr, rd_n, byte_lines,
    output tx_space_n, rx_avail_n, dev_data, dev_oe_n
  );
  modport host
  (
    input  tx_space_n, rx_avail_n, byte_lines,
    output wr, rd_n, host_data, host_oe_n
  );
endinterface : ufbp_link_if

/* design/ufbp_buf2.sv */
// two-entry byte buffer with valid and ready on both sides
module ufbp_buf2
(
  input  wire logic       clk_in,     // system clock
  input  wire logic       srst_in,    // synchronous reset
  input  wire logic       in_valid_in, // byte offered
  input  wire logic [7:0] in_data_in,  // byte offered
  output logic            in_ready_out, // room for a byte, registered
  output logic            out_valid_out, // head byte valid, registered
  output logic      [7:0] out_data_out,  // head byte, registered
  input  wire logic       out_ready_in   // drain side takes head
);
  logic [1:0] count;       // fill level
  logic [1:0] next_count;
  logic [7:0] tail;        // second entry
  logic [7:0] next_tail;
  logic [7:0] next_head;
  logic       push;
  logic       pop;

  // next fill and entries; head is always the oldest byte
  always_comb
  begin
    push = in_valid_in && in_ready_out;
    pop  = out_valid_out && out_ready_in;
    next_count = count;
    next_head  = out_data_out;
    next_tail  = tail;
    case ({push, pop})
      2'b10:
      begin
        next_count = count + ufbp_pkg::CNT_ONE;
        if (count == ufbp_pkg::CNT_EMPTY)
          next_head = in_data_in;  // empty: straight to head
        else
          next_tail = in_data_in;
      end
      2'b01:
      begin
        next_count = count - ufbp_pkg::CNT_ONE;
        next_head  = tail;          // shift tail forward
      end
      2'b11:
      begin
        if (count == ufbp_pkg::CNT_ONE)
          next_head = in_data_in;
        else
        begin
          next_head = tail;
          next_tail = in_data_in;
        end
      end
      default: ;
    endcase
  end

  // register entries and the honest full and empty flags
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      count         <= ufbp_pkg::CNT_EMPTY;
      out_data_out  <= ufbp_pkg::IDLE_BYTE;
      tail          <= ufbp_pkg::IDLE_BYTE;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end
    else
    begin
      count         <= next_count;
      out_data_out  <= next_head;
      tail          <= next_tail;
      in_ready_out  <= (next_count != ufbp_pkg::CNT_FULL);
      out_valid_out <= (next_count != ufbp_pkg::CNT_EMPTY);
    end
  end
endmodule : ufbp_buf2

/* design/ufbp_dev_end.sv */
// usb chip end of the byte port: holds pc bytes and takes logic bytes
module ufbp_dev_end
(
  input  wire logic       clk_in,          // system clock
  input  wire logic       srst_in,         // synchronous reset
  ufbp_link_if.dev        link,            // shared link
  input  wire logic       pc_rx_valid_in,  // byte from the pc offered
  input  wire logic [7:0] pc_rx_data_in,   // byte from the pc
  output logic            pc_rx_ready_out, // holding register free
  output logic            pc_tx_valid_out, // byte toward the pc
  output logic      [7:0] pc_tx_data_out,  // byte toward the pc
  input  wire logic       pc_tx_ready_in   // pc side takes the byte
);
  logic [2:0] wr_sync;    // wr through two flops plus edge history
  logic [1:0] rd_sync;    // rd_n through two flops
  logic [7:0] ln_s1;      // byte lines, first stage
  logic [7:0] ln_s2;      // byte lines, second stage
  logic [7:0] rx_hold;    // unread byte from the pc
  logic [7:0] next_rx_hold;
  logic       rx_full;    // holding register occupied
  logic       next_rx_full;
  logic       rd_seen;    // previous synced rd_n, for the rising edge
  logic       wr_fall;
  logic       buf_ready;
  logic       next_space_n;

  // the link pins enter two flops before anything looks at them
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      wr_sync <= 3'h0;
      rd_sync <= 2'h3;
      rd_seen <= 1'b1;
      ln_s1   <= ufbp_pkg::IDLE_BYTE;
      ln_s2   <= ufbp_pkg::IDLE_BYTE;
    end
    else
    begin
      wr_sync <= {wr_sync[1:0], link.wr};
      rd_sync <= {rd_sync[0], link.rd_n};
      rd_seen <= rd_sync[1];
      ln_s1   <= link.byte_lines;
      ln_s2   <= ln_s1;
    end
  end

  // the byte is taken on the falling edge of the write strobe
  assign wr_fall = wr_sync[2] && !wr_sync[1]; // RULE4

  // logic bytes queue toward the pc; a stalled pc fills the buffer
  ufbp_buf2 u_txbuf
  (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (wr_fall),         // RULE4
    .in_data_in    (ln_s2),           // RULE1
    .in_ready_out  (buf_ready),
    .out_valid_out (pc_tx_valid_out),
    .out_data_out  (pc_tx_data_out),
    .out_ready_in  (pc_tx_ready_in)
  );

  // holding register: load from the pc, empty when the read ends
  always_comb
  begin
    next_rx_hold = rx_hold;
    next_rx_full = rx_full;
    if (rx_full && rd_sync[1] && !rd_seen)
      next_rx_full = 1'b0;            // RULE7
    else if (pc_rx_ready_out && pc_rx_valid_in) // only a flagged free slot
    begin
      next_rx_hold = pc_rx_data_in;
      next_rx_full = 1'b1;
    end
    // no room flag stays high until the write has settled in the buffer
    next_space_n = !buf_ready || wr_fall;
  end

  // flags and bus drive are registered straight onto the link
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rx_hold         <= ufbp_pkg::IDLE_BYTE;
      rx_full         <= 1'b0;
      pc_rx_ready_out <= 1'b0;
      link.rx_avail_n <= 1'b1;
      link.tx_space_n <= 1'b1;
      link.dev_oe_n   <= 1'b1;
      link.dev_data   <= ufbp_pkg::IDLE_BYTE;
    end
    else
    begin
      rx_hold         <= next_rx_hold;
      rx_full         <= next_rx_full;
      pc_rx_ready_out <= !next_rx_full;
      link.rx_avail_n <= !next_rx_full;                 // RULE5
      link.tx_space_n <= next_space_n;
      // drive the held byte only while the strobe is seen low
      link.dev_oe_n   <= !(rx_full && !rd_sync[1]);      // RULE6 RULE7
      link.dev_data   <= rx_hold;                        // RULE6
    end
  end
endmodule : ufbp_dev_end

/* design/ufbp_host_end.sv */
// logic end of the byte port: polls the flags and runs both strobes
// Summary of operation
// [RULE1] bytes cross both ways on eight shared lines
// [RULE2] wait for transmit space flag low before writing
// [RULE3] drive byte, pulse write strobe, then release lines
// [RULE4] chip takes byte on write strobe fall
// [RULE5] read only while receive flag is low
// [RULE6] chip drives byte while read strobe low
// [RULE7] capture byte, raise strobe, chip releases lines
// [RULE8] other devices use lines only when idle
// [RULE9] received bytes feed a command interpreter
// [RULE10] never drive lines while read strobe low
module ufbp_host_end
(
  input  wire logic       clk_in,        // system clock
  input  wire logic       srst_in,       // synchronous reset
  ufbp_link_if.host       link,          // shared link
  input  wire logic       tx_valid_in,   // byte to send offered
  input  wire logic [7:0] tx_data_in,    // byte to send
  output logic            tx_ready_out,  // byte taken this cycle
  output logic            rx_valid_out,  // received byte valid
  output logic      [7:0] rx_data_out,   // received byte
  input  wire logic       rx_ready_in,   // command logic takes byte
  input  wire logic       aux_req_in,    // other device wants lines
  input  wire logic [7:0] aux_data_in,   // byte for the other device
  output logic            aux_grant_out, // lines handed over
  output logic      [7:0] aux_lines_out  // synced level of the lines
);
  ufbp_pkg::ufbp_state_e state;       // sequencer state
  ufbp_pkg::ufbp_state_e next_state;
  logic [3:0] cnt;                    // phase counter
  logic [3:0] next_cnt;
  logic [7:0] tx_byte;                // byte being written
  logic [7:0] next_tx_byte;
  logic [1:0] space_sync;             // tx_space_n through two flops
  logic [1:0] avail_sync;             // rx_avail_n through two flops
  logic [7:0] ln_s1;                  // byte lines, first stage
  logic [7:0] ln_s2;                  // byte lines, second stage
  logic       buf_ready;              // receive buffer has room
  logic       rd_capture;             // last cycle of the read phase
  logic       rx_want;                // a read may start now
  logic       next_tx_ready;
  logic       next_wr;
  logic       next_rd_n;
  logic       next_oe_n;
  logic [7:0] next_drive;

  // load a phase counter with a length, counted down to zero
  function automatic logic [3:0] ufbp_load(input logic [3:0] len);
    ufbp_load = len - ufbp_pkg::ONE;
  endfunction : ufbp_load

  // the chip's pins enter two flops before anything looks at them
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      space_sync <= 2'h3;
      avail_sync <= 2'h3;
      ln_s1      <= ufbp_pkg::IDLE_BYTE;
      ln_s2      <= ufbp_pkg::IDLE_BYTE;
    end
    else
    begin
      space_sync <= {space_sync[0], link.tx_space_n};
      avail_sync <= {avail_sync[0], link.rx_avail_n};
      ln_s1      <= link.byte_lines;
      ln_s2      <= ln_s1;
    end
  end

  // a read starts only on a low receive flag and with room to keep it
  assign rx_want    = !avail_sync[1] && buf_ready;               // RULE5
  assign rd_capture = (state == ufbp_pkg::ST_RDLO) &&
                      (cnt == 4'h0);                             // RULE7

  // received bytes wait here for the command interpreter
  ufbp_buf2 u_rxbuf
  (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (rd_capture),   // RULE7
    .in_data_in    (ln_s2),        // RULE1
    .in_ready_out  (buf_ready),
    .out_valid_out (rx_valid_out), // RULE9
    .out_data_out  (rx_data_out),  // RULE9
    .out_ready_in  (rx_ready_in)   // RULE9
  );

  // sequencer: next state, counter and the byte being sent
  always_comb
  begin
    next_state   = state;
    next_cnt     = cnt;
    next_tx_byte = tx_byte;
    case (state)
      ufbp_pkg::ST_IDLE:
      begin
        // a write already promised by tx_ready_out goes first
        if (tx_ready_out && tx_valid_in)
        begin
          next_tx_byte = tx_data_in;
          next_state   = ufbp_pkg::ST_SETUP;               // RULE2
          next_cnt     = ufbp_load(ufbp_pkg::SETUP_CYC);
        end
        else if (rx_want)
        begin
          next_state = ufbp_pkg::ST_RDLO;                  // RULE5
          next_cnt   = ufbp_load(ufbp_pkg::RDLO_CYC);
        end
        else if (aux_req_in)
          next_state = ufbp_pkg::ST_AUX;                   // RULE8
      end
      ufbp_pkg::ST_SETUP:
      begin
        // byte sits on the lines before the strobe rises
        if (cnt == 4'h0)
        begin
          next_state = ufbp_pkg::ST_WRHI;                  // RULE3
          next_cnt   = ufbp_load(ufbp_pkg::WRHI_CYC);
        end
        else
          next_cnt = cnt - ufbp_pkg::ONE;
      end
      ufbp_pkg::ST_WRHI:
      begin
        // strobe high, then low: the fall hands the byte over
        if (cnt == 4'h0)
        begin
          next_state = ufbp_pkg::ST_HOLD;                  // RULE3
          next_cnt   = ufbp_load(ufbp_pkg::HOLD_CYC);
        end
        else
          next_cnt = cnt - ufbp_pkg::ONE;
      end
      ufbp_pkg::ST_HOLD:
      begin
        // keep the byte while the chip sees the fall, then let go
        if (cnt == 4'h0)
        begin
          next_state = ufbp_pkg::ST_GUARD;                 // RULE3
          next_cnt   = ufbp_load(ufbp_pkg::GUARD_CYC);
        end
        else
          next_cnt = cnt - ufbp_pkg::ONE;
      end
      ufbp_pkg::ST_RDLO:
      begin
        // strobe low long enough for the chip's byte to arrive
        if (cnt == 4'h0)
        begin
          next_state = ufbp_pkg::ST_GUARD;                 // RULE7
          next_cnt   = ufbp_load(ufbp_pkg::GUARD_CYC);
        end
        else
          next_cnt = cnt - ufbp_pkg::ONE;
      end
      ufbp_pkg::ST_GUARD:
      begin
        // let the chip release the lines and update its flags
        if (cnt == 4'h0)
          next_state = ufbp_pkg::ST_IDLE;                  // RULE10
        else
          next_cnt = cnt - ufbp_pkg::ONE;
      end
      ufbp_pkg::ST_AUX:
      begin
        // lines stay with the other device while it asks
        if (!aux_req_in)
          next_state = ufbp_pkg::ST_IDLE;                  // RULE8
      end
      default:
      begin
        next_state = ufbp_pkg::ST_IDLE;
        next_cnt   = 4'h0;
      end
    endcase
  end

  // pin values follow the next state so they change with it
  always_comb
  begin
    next_wr    = (next_state == ufbp_pkg::ST_WRHI);          // RULE3
    next_rd_n  = (next_state != ufbp_pkg::ST_RDLO);          // RULE7
    // drive only in write phases or for the other device
    next_oe_n  = !((next_state == ufbp_pkg::ST_SETUP) ||
                   (next_state == ufbp_pkg::ST_WRHI)  ||
                   (next_state == ufbp_pkg::ST_HOLD)  ||
                   (next_state == ufbp_pkg::ST_AUX));        // RULE10
    next_drive = (next_state == ufbp_pkg::ST_AUX) ? aux_data_in
                                                  : next_tx_byte;
    // promise a write only when idle, space is flagged and no read waits
    next_tx_ready = (next_state == ufbp_pkg::ST_IDLE) &&
                    (state == ufbp_pkg::ST_IDLE) &&
                    !tx_ready_out && !space_sync[1] &&
                    !rx_want;                                // RULE2
  end

  // register sequencer and every pin
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      state          <= ufbp_pkg::ST_IDLE;
      cnt            <= 4'h0;
      tx_byte        <= ufbp_pkg::IDLE_BYTE;
      tx_ready_out   <= 1'b0;
      aux_grant_out  <= 1'b0;
      aux_lines_out  <= ufbp_pkg::IDLE_BYTE;
      link.wr        <= 1'b0;
      link.rd_n      <= 1'b1;
      link.host_oe_n <= 1'b1;
      link.host_data <= ufbp_pkg::IDLE_BYTE;
    end
    else
    begin
      state          <= next_state;
      cnt            <= next_cnt;
      tx_byte        <= next_tx_byte;
      tx_ready_out   <= next_tx_ready;
      aux_grant_out  <= (next_state == ufbp_pkg::ST_AUX);   // RULE8
      aux_lines_out  <= ln_s2;
      link.wr        <= next_wr;
      link.rd_n      <= next_rd_n;
      link.host_oe_n <= next_oe_n;                          // RULE10
      link.host_data <= next_drive;                         // RULE1
    end
  end
endmodule : ufbp_host_end

/* sim/ufbp_link_chk.sv */
// link protocol assertions for the usb fifo byte port
module ufbp_link_chk
(
  input wire logic       clk_in,        // system clock
  input wire logic       srst_in,       // synchronous reset
  input wire logic       tx_space_n_in, // chip room flag
  input wire logic       rx_avail_n_in, // chip data flag
  input wire logic       wr_in,         // write strobe
  input wire logic       rd_n_in,       // read strobe
  input wire logic       host_oe_n_in,  // logic end drive, low drives
  input wire logic       dev_oe_n_in,   // chip end drive, low drives
  input wire logic [7:0] byte_lines_in  // resolved shared lines
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain, so one clocking and one reset for all
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  // never both ends on the lines at once
  chk_no_contend: assert property
    (host_oe_n_in || dev_oe_n_in)
    else $error("both ends drive the byte lines");
  // logic end stays off the lines while the chip may drive
  chk_rd_quiet: assert property
    (!rd_n_in |-> host_oe_n_in)
    else $error("logic end drives during read strobe");
  // a write starts only after room was seen
  chk_wr_space: assert property
    ($rose(wr_in) |-> !$past(tx_space_n_in, 2))
    else $error("write strobe without room");
  // a read starts only when the chip holds a byte
  chk_rd_avail: assert property
    ($fell(rd_n_in) |-> !$past(rx_avail_n_in, 2))
    else $error("read strobe without data");
  // write strobe is a two cycle high pulse
  chk_wr_pulse: assert property
    ($rose(wr_in) |-> wr_in[*2] ##1 !wr_in)
    else $error("write strobe width wrong");
  // byte driven and steady while the strobe is high
  chk_wr_setup: assert property
    (wr_in |-> !host_oe_n_in && $stable(byte_lines_in))
    else $error("byte not steady under write strobe");
  // byte held three cycles past the fall, then released
  chk_wr_hold: assert property
    ($fell(wr_in) |->
     (!host_oe_n_in && $stable(byte_lines_in))[*3] ##1 host_oe_n_in)
    else $error("byte hold or release after write wrong");
  // read strobe stays low seven cycles
  chk_rd_len: assert property
    ($fell(rd_n_in) |-> !rd_n_in[*7] ##1 rd_n_in)
    else $error("read strobe width wrong");
  // chip drives from three cycles into the read strobe
  chk_dev_drive: assert property
    ($fell(rd_n_in) |-> ##3 (!dev_oe_n_in)[*4])
    else $error("chip not driving during read");
  // chip starts driving only under a read strobe
  chk_dev_only: assert property
    ($fell(dev_oe_n_in) |-> !rd_n_in)
    else $error("chip drives without read strobe");
  // chip lets go three cycles after the strobe rises
  chk_dev_free: assert property
    ($rose(rd_n_in) |-> ##3 dev_oe_n_in)
    else $error("chip keeps the lines after read");
endmodule : ufbp_link_chk

/* sim/usb_fifo_byte_port_tb.sv */
// self-checking bench joining both ends of the usb fifo byte port
module usb_fifo_byte_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // one row: byte toward the pc, byte from the pc
  typedef struct packed {logic [7:0] up; logic [7:0] down;} ufbp_row_s;
  ufbp_row_s  rows [4] = '{'{8'h00, 8'hff}, '{8'hff, 8'h00},
                           '{8'ha5, 8'h5a}, '{8'h01, 8'h80}};
  logic       clk_in, srst_in;            // clock and reset
  logic       tx_valid, tx_ready;         // logic end send side
  logic [7:0] tx_data;
  logic       rx_valid, rx_ready;         // logic end receive side
  logic [7:0] rx_data;
  logic       aux_req, aux_grant;         // other device on the lines
  logic [7:0] aux_data, aux_lines;
  logic       pc_rx_valid, pc_rx_ready;   // pc feeds the chip end
  logic [7:0] pc_rx_data;
  logic       pc_tx_valid, pc_tx_ready;   // chip end feeds the pc
  logic [7:0] pc_tx_data;
  logic [7:0] exp_up [$];                 // bytes owed to the pc
  logic [7:0] exp_down [$];               // bytes owed to the logic
  int         mismatches = 0;
  int         cmp_count = 0;

  ufbp_link_if ufbp_link_if_i ();
  ufbp_host_end ufbp_host_end_i
  (
    .clk_in (clk_in), .srst_in (srst_in), .link (ufbp_link_if_i),
    .tx_valid_in (tx_valid), .tx_data_in (tx_data),
    .tx_ready_out (tx_ready), .rx_valid_out (rx_valid),
    .rx_data_out (rx_data), .rx_ready_in (rx_ready),
    .aux_req_in (aux_req), .aux_data_in (aux_data),
    .aux_grant_out (aux_grant), .aux_lines_out (aux_lines)
  );
  ufbp_dev_end ufbp_dev_end_i
  (
    .clk_in (clk_in), .srst_in (srst_in), .link (ufbp_link_if_i),
    .pc_rx_valid_in (pc_rx_valid), .pc_rx_data_in (pc_rx_data),
    .pc_rx_ready_out (pc_rx_ready), .pc_tx_valid_out (pc_tx_valid),
    .pc_tx_data_out (pc_tx_data), .pc_tx_ready_in (pc_tx_ready)
  );
  ufbp_link_chk ufbp_link_chk_i
  (
    .clk_in (clk_in), .srst_in (srst_in),
    .tx_space_n_in (ufbp_link_if_i.tx_space_n),
    .rx_avail_n_in (ufbp_link_if_i.rx_avail_n),
    .wr_in (ufbp_link_if_i.wr), .rd_n_in (ufbp_link_if_i.rd_n),
    .host_oe_n_in (ufbp_link_if_i.host_oe_n),
    .dev_oe_n_in (ufbp_link_if_i.dev_oe_n),
    .byte_lines_in (ufbp_link_if_i.byte_lines)
  );

  // 100 ns clock
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // compare one value and count it
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, want, seen);
    end
  endtask : chk

  // print the counts and the verdict, then end
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // score a delivered byte against the oldest owed one
  task automatic take(input string what, input logic [7:0] seen,
                      ref logic [7:0] q [$]);
    logic [7:0] want;
    want = 8'hxx;
    if (q.size() != 0)
    begin
      want = q.pop_front();
    end
    chk(what, seen, want);
  endtask : take

  // bounded wait for a handshake flag, a hang ends the run
  task automatic wait_hi(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 400)
    begin
      @(negedge clk_in);
      n++;
    end
    if (sig !== 1'b1)
    begin
      chk("handshake", {7'h00, sig}, 8'h01);
      stop_test();
    end
  endtask : wait_hi

  // offer one byte to the logic end until it is taken
  task automatic put_up(input logic [7:0] b);
    @(negedge clk_in);
    tx_data = b;
    tx_valid = 1'b1;
    wait_hi(tx_ready);
    @(negedge clk_in);
    tx_valid = 1'b0;
  endtask : put_up

  // offer one pc byte to the chip end until it is taken
  task automatic put_down(input logic [7:0] b);
    @(negedge clk_in);
    pc_rx_data = b;
    pc_rx_valid = 1'b1;
    wait_hi(pc_rx_ready);
    @(negedge clk_in);
    pc_rx_valid = 1'b0;
  endtask : put_down

  // pre-edge sampling of both stream outputs
  always @(posedge clk_in)
  begin
    if (pc_tx_valid === 1'b1 && pc_tx_ready === 1'b1)
    begin
      take("up byte", pc_tx_data, exp_up);
    end
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
    begin
      take("down byte", rx_data, exp_down);
    end
  end

  // watchdog against a hang anywhere
  initial
  begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    stop_test();
  end

  // main sequence
  initial
  begin
    srst_in = 1'b1;
    {tx_valid, rx_ready, aux_req, pc_rx_valid, pc_tx_ready} = 5'h09;
    {tx_data, aux_data, pc_rx_data} = 24'h000000;
    repeat (8) @(negedge clk_in);
    // idle levels of the link under reset
    chk("wr idle", {7'h00, ufbp_link_if_i.wr}, 8'h00);
    chk("rd idle", {7'h00, ufbp_link_if_i.rd_n}, 8'h01);
    chk("lines idle", ufbp_link_if_i.byte_lines, 8'hff);
    srst_in = 1'b0;
    // table rows: both directions at once
    foreach (rows[i])
    begin
      exp_up.push_back(rows[i].up);
      exp_down.push_back(rows[i].down);
      fork
        put_up(rows[i].up);
        put_down(rows[i].down);
      join
    end
    // both receivers stall until the buffers refuse
    // bytes of the last row may still be in flight, so append
    exp_up = {exp_up, 8'h11, 8'h22, 8'h33};
    exp_down = {exp_down, 8'h44, 8'h55, 8'h66};
    {pc_tx_ready, rx_ready} = 2'h0;
    fork
      begin
        put_up(8'h11);
        put_up(8'h22);
        put_up(8'h33);
      end
      begin
        put_down(8'h44);
        put_down(8'h55);
        put_down(8'h66);
      end
      begin
        repeat (120) @(negedge clk_in);
        chk("full space", {7'h00, ufbp_link_if_i.tx_space_n}, 8'h01);
        chk("held avail", {7'h00, ufbp_link_if_i.rx_avail_n}, 8'h00);
        chk("hold busy", {7'h00, pc_rx_ready}, 8'h00);
        {pc_tx_ready, rx_ready} = 2'h3;
      end
    join
    // let the owed bytes drain
    repeat (80) @(negedge clk_in);
    chk("owed", 8'(exp_up.size() + exp_down.size()), 8'h00);
    // lines handed to another device while idle
    aux_data = 8'h3c;
    aux_req = 1'b1;
    wait_hi(aux_grant);
    repeat (4) @(negedge clk_in);
    chk("aux lines", ufbp_link_if_i.byte_lines, 8'h3c);
    chk("aux seen", aux_lines, 8'h3c);
    chk("aux rd", {7'h00, ufbp_link_if_i.rd_n}, 8'h01);
    aux_req = 1'b0;
    repeat (3) @(negedge clk_in);
    chk("aux free", {7'h00, ufbp_link_if_i.host_oe_n}, 8'h01);
    // reset in mid-read: the held byte is dropped and the link rests
    put_down(8'h77);
    repeat (4) @(negedge clk_in);
    srst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk("rst rd", {7'h00, ufbp_link_if_i.rd_n}, 8'h01);
    chk("rst oe", {7'h00, ufbp_link_if_i.dev_oe_n}, 8'h01);
    chk("rst avail", {7'h00, ufbp_link_if_i.rx_avail_n}, 8'h01);
    chk("rst valid", {7'h00, rx_valid}, 8'h00);
    chk("rst up", {7'h00, pc_tx_valid}, 8'h00);
    srst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("rst ready", {7'h00, pc_rx_ready}, 8'h01);
    chk("rst space", {7'h00, ufbp_link_if_i.tx_space_n}, 8'h00);
    stop_test();
  end
endmodule : usb_fifo_byte_port_tb
